//--- design/lpd_consts.svh
// Constants for the palette/dither datapath.
// Assumes inclusion by the package and the dither and datapath modules.
`ifndef LPD_CONSTS_SVH
`define LPD_CONSTS_SVH
`define LPD_WORD_W 32
`define LPD_PIX_W 24
`define LPD_PAL_DEPTH 256
`define LPD_PAL_AW 8
`define LPD_PAL_DW 16
`define LPD_FIFO_DEPTH 32
`define LPD_KIND_TFT_C 2'h0
`define LPD_KIND_MONO_C 2'h1
`define LPD_KIND_COLOR_C 2'h2
`define LPD_BPP1_C 3'h0
`define LPD_BPP2_C 3'h1
`define LPD_BPP4_C 3'h2
`define LPD_BPP8_C 3'h3
`define LPD_BPP16_C 3'h4
`define LPD_BPP24_C 3'h5
`define LPD_ORDER_BIG 1'b1
`define LPD_RED_MSB 15
`define LPD_RED_LSB 11
`define LPD_GRN_MSB 10
`define LPD_GRN_LSB 5
`define LPD_BLU_MSB 4
`define LPD_PAT_W 28
`define LPD_GRP_6_7 4'h7
`define LPD_GRP_4_5 4'h5
`define LPD_GRP_3_4 4'h4
`define LPD_GRP_5_7 4'h7
`define LPD_GRP_2_3 4'h3
`define LPD_GRP_3_5 4'h5
`define LPD_GRP_4_7 4'h7
`define LPD_GRP_1_2 4'h2
`define LPD_FRAME_MOD 9'h1A4
`define LPD_SHADE_FULL 4'hF
`define LPD_SHADE_NONE 4'h0
`endif

//--- design/lpd_pkg.sv
// Types of the palette/dither datapath.
// Assumes lpd_consts.svh on the include path.
package lpd_pkg;
  `include "lpd_consts.svh"
  typedef enum logic [1:0] {
    LPD_TFT = `LPD_KIND_TFT_C,
    LPD_MONO = `LPD_KIND_MONO_C,
    LPD_COLOR = `LPD_KIND_COLOR_C
  } lpd_kind_e;
  typedef enum logic [2:0] {
    LPD_B1 = `LPD_BPP1_C,
    LPD_B2 = `LPD_BPP2_C,
    LPD_B4 = `LPD_BPP4_C,
    LPD_B8 = `LPD_BPP8_C,
    LPD_B16 = `LPD_BPP16_C,
    LPD_B24 = `LPD_BPP24_C
  } lpd_bpp_e;
endpackage

//--- design/lpd_fifo.sv
// Word FIFO between the memory fetch side and the serializer.
// Assumes both sides on one clock; valid/ready on each side.
`timescale 1ns/1ns
module lpd_fifo #(
  parameter int W = 32,
  parameter int DEPTH = 32,
  parameter int AW = 5
) (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  logic [W-1:0] mem [DEPTH];
  logic [AW-1:0] wr_q;
  logic [AW-1:0] rd_q;
  logic [AW:0] cnt_q;
  logic push;
  logic pop;

  assign in_ready_o = (cnt_q != (AW+1)'(DEPTH));
  assign out_valid_o = (cnt_q != '0);
  assign out_data_o = mem[rd_q];
  assign push = in_valid_i & in_ready_o;
  assign pop = out_valid_o & out_ready_i;

  always_ff @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      wr_q <= '0;
      rd_q <= '0;
      cnt_q <= '0;
    end else begin
      if (push) begin
        wr_q <= (wr_q == AW'(DEPTH - 1)) ? '0 : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == AW'(DEPTH - 1)) ? '0 : rd_q + 1'b1;
      end
      cnt_q <= cnt_q + (AW+1)'(push) - (AW+1)'(pop);
    end
  end

  property p_fifo_full;
    @(posedge clk_i) disable iff (!nrst_i)
    (cnt_q == (AW+1)'(DEPTH)) && !pop |-> !in_ready_o ##1 (cnt_q == (AW+1)'(DEPTH));
  endproperty
  a_fifo_full: assert property (p_fifo_full) else $error("fifo accepted while full");
endmodule // lpd_fifo

//--- design/lpd_dither.sv
// Frame-rate-control dither for one shade channel.
// Assumes frame_i counts frames modulo 420, x_i is position mod 4.
`timescale 1ns/1ns
module lpd_dither (
  input wire logic [3:0] shade_i,
  input wire logic [1:0] x_i,
  input wire logic [8:0] frame_i,
  input wire logic [27:0] pat_six_sevenths_i,
  input wire logic [27:0] pat_four_fifths_i,
  input wire logic [27:0] pat_three_quarters_i,
  input wire logic [27:0] pat_five_sevenths_i,
  input wire logic [27:0] pat_two_thirds_i,
  input wire logic [27:0] pat_three_fifths_i,
  input wire logic [27:0] pat_four_sevenths_i,
  input wire logic [27:0] pat_one_half_i,
  output logic on_o
);
  `include "lpd_consts.svh"
  // First group sits in the top used nibble
  function automatic logic [3:0] group_of(input logic [27:0] pat, input logic [3:0] n,
                                          input logic [8:0] f);
    logic [8:0] g;
    logic [4:0] b;
    g = f % {5'h00, n};
    b = 5'(({1'b0, n} - 5'h01 - {1'b0, g[3:0]}) << 2);
    group_of = pat[b +: 4];
  endfunction

  logic [3:0] grp;
  logic inv;

  always_comb begin
    grp = 4'h0;
    inv = 1'b0;
    case (shade_i)
      4'hE: grp = group_of(pat_six_sevenths_i, `LPD_GRP_6_7, frame_i);
      4'hD: grp = group_of(pat_four_fifths_i, `LPD_GRP_4_5, frame_i);
      4'hC: grp = group_of(pat_three_quarters_i, `LPD_GRP_3_4, frame_i);
      4'hB: grp = group_of(pat_five_sevenths_i, `LPD_GRP_5_7, frame_i);
      4'hA: grp = group_of(pat_two_thirds_i, `LPD_GRP_2_3, frame_i);
      4'h9: grp = group_of(pat_three_fifths_i, `LPD_GRP_3_5, frame_i);
      4'h8: grp = group_of(pat_four_sevenths_i, `LPD_GRP_4_7, frame_i);
      4'h7: begin
        grp = group_of(pat_one_half_i, `LPD_GRP_1_2, frame_i);
        inv = 1'b1;
      end
      4'h6: begin
        grp = group_of(pat_four_sevenths_i, `LPD_GRP_4_7, frame_i);
        inv = 1'b1;
      end
      4'h5: begin
        grp = group_of(pat_three_fifths_i, `LPD_GRP_3_5, frame_i);
        inv = 1'b1;
      end
      4'h4: begin
        grp = group_of(pat_two_thirds_i, `LPD_GRP_2_3, frame_i);
        inv = 1'b1;
      end
      4'h3: begin
        grp = group_of(pat_three_quarters_i, `LPD_GRP_3_4, frame_i);
        inv = 1'b1;
      end
      4'h2: begin
        grp = group_of(pat_four_fifths_i, `LPD_GRP_4_5, frame_i);
        inv = 1'b1;
      end
      4'h1: begin
        grp = group_of(pat_six_sevenths_i, `LPD_GRP_6_7, frame_i);
        inv = 1'b1;
      end
      default: grp = 4'h0;
    endcase
  end

  // Bit (3-m) of the group: ~m for a 2-bit m
  assign on_o = (shade_i == `LPD_SHADE_FULL) |
                ((shade_i != `LPD_SHADE_NONE) & (grp[~x_i] ^ inv));
endmodule // lpd_dither

//--- design/lpd_datapath.sv
// Serializer, palette and dither stages of the LCD datapath.
// Assumes frame/line strobes and config come from logic on CLK_I.
//
// Contract
// - Big-endian: lowest-numbered pixel of a word comes from the top bits.
// - Palette used only for palettized kind and pixel-size pairs.
// - Palettized pixel bits index the table; entry gives colour or shade.
// - Host reads and writes palette as word-aligned half-words, upper bits unused.
// - Palette has 256 entries of 16 bits, any value storable.
// - Entry layout is red 5, green 6, blue 5, from the top.
// - STN mono uses the top four red bits as a 16-level shade; unpaletted mono takes pixel bits 3:0 as the shade.
// - STN colour uses the top four bits of each component.
// - Palettized TFT zeroes panel data bits 18:16, 9:8 and 2:0.
// - STN pixels switch on/off per frame by shade and horizontal position.
// - Shade 15 always on, 0 always off, others at set duty cycles.
// - Shades 1 to 7 use the inverted pattern of the complementary level.
// - Pixel at 4n+m takes bit 3-m of the frame's pattern.
// - Pattern groups advance one per frame and wrap after the last.
// - Each pattern setting holds a series of 4-bit groups.
// - Both big- and little-endian pixel orders are supported.
// - Display kind selects TFT, STN mono or STN colour.
`timescale 1ns/1ns
`include "lpd_consts.svh"
module lpd_datapath #(
  parameter int FIFO_DEPTH = `LPD_FIFO_DEPTH
) (
  input wire logic CLK_I,
  input wire logic NRST_I,
  input wire logic ENABLE_I,
  input wire logic FRAME_START_I,
  input wire logic LINE_START_I,
  input wire lpd_pkg::lpd_kind_e DISPLAY_KIND_I,
  input wire lpd_pkg::lpd_bpp_e BITS_PER_PIXEL_SEL_I,
  input wire logic MEMORY_ORDER_SEL_I,
  input wire logic [27:0] PATTERN_SIX_SEVENTHS_I,
  input wire logic [27:0] PATTERN_FOUR_FIFTHS_I,
  input wire logic [27:0] PATTERN_THREE_QUARTERS_I,
  input wire logic [27:0] PATTERN_FIVE_SEVENTHS_I,
  input wire logic [27:0] PATTERN_TWO_THIRDS_I,
  input wire logic [27:0] PATTERN_THREE_FIFTHS_I,
  input wire logic [27:0] PATTERN_FOUR_SEVENTHS_I,
  input wire logic [27:0] PATTERN_ONE_HALF_I,
  input wire logic WORD_VALID_I,
  input wire logic [31:0] WORD_DATA_I,
  output logic WORD_READY_O,
  input wire logic PAL_SEL_I,
  input wire logic PAL_WE_I,
  input wire logic [7:0] PAL_ADDR_I,
  input wire logic [31:0] PAL_WDATA_I,
  output logic [31:0] PAL_RDATA_O,
  output logic OUT_VALID_O,
  output logic [23:0] OUT_DATA_O,
  input wire logic OUT_READY_I
);

  // ----------------------------------------------------------------
  // Helper functions
  // ----------------------------------------------------------------
  function automatic logic is_pal(input lpd_pkg::lpd_kind_e k, input lpd_pkg::lpd_bpp_e b);
    case (k)
      lpd_pkg::LPD_TFT: is_pal = (b <= lpd_pkg::LPD_B8);
      lpd_pkg::LPD_MONO: is_pal = (b <= lpd_pkg::LPD_B2);
      lpd_pkg::LPD_COLOR: is_pal = (b <= lpd_pkg::LPD_B8);
      default: is_pal = 1'b0;
    endcase
  endfunction

  function automatic logic [4:0] last_idx(input lpd_pkg::lpd_bpp_e b);
    case (b)
      lpd_pkg::LPD_B1: last_idx = 5'h1F;
      lpd_pkg::LPD_B2: last_idx = 5'h0F;
      lpd_pkg::LPD_B4: last_idx = 5'h07;
      lpd_pkg::LPD_B8: last_idx = 5'h03;
      lpd_pkg::LPD_B16: last_idx = 5'h01;
      default: last_idx = 5'h00;
    endcase
  endfunction

  // 24 bpp carries one pixel per word in the low bits
  function automatic logic [23:0] pick_pixel(input logic [31:0] w,
                                             input lpd_pkg::lpd_bpp_e b,
                                             input logic [4:0] i, input logic big);
    logic [5:0] wd;
    logic [5:0] lsb;
    logic [5:0] sh;
    logic [31:0] s;
    wd = 6'h01 << b;
    lsb = 6'({1'b0, i} << b);
    sh = big ? 6'h20 - wd - lsb : lsb;
    s = (w >> sh) & ((32'h1 << wd) - 32'h1);
    pick_pixel = (b == lpd_pkg::LPD_B24) ? w[23:0] : s[23:0];
  endfunction

  // ----------------------------------------------------------------
  // Input FIFO
  // ----------------------------------------------------------------
  logic f_valid;
  logic [31:0] f_data;
  logic f_ready;

  lpd_fifo #(
    .W(`LPD_WORD_W),
    .DEPTH(FIFO_DEPTH),
    .AW($clog2(FIFO_DEPTH))
  ) u_fifo (
    .clk_i(CLK_I),
    .nrst_i(NRST_I),
    .in_valid_i(WORD_VALID_I),
    .in_data_i(WORD_DATA_I),
    .in_ready_o(WORD_READY_O),
    .out_valid_o(f_valid),
    .out_data_o(f_data),
    .out_ready_i(f_ready)
  );

  // ----------------------------------------------------------------
  // Palette memory and host port
  // ----------------------------------------------------------------
  logic [15:0] pal_mem [`LPD_PAL_DEPTH];
  logic [15:0] rdata_q;
  logic [15:0] wdata_lo;

  assign wdata_lo = PAL_WDATA_I[15:0];

  always_ff @(posedge CLK_I) begin
    if (PAL_SEL_I && PAL_WE_I) begin
      pal_mem[PAL_ADDR_I] <= wdata_lo;
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      rdata_q <= 16'h0000;
    end else if (PAL_SEL_I && !PAL_WE_I) begin
      rdata_q <= pal_mem[PAL_ADDR_I];
    end
  end

  assign PAL_RDATA_O = {16'h0000, rdata_q};

  // ----------------------------------------------------------------
  // Frame pattern index
  // ----------------------------------------------------------------
  logic [8:0] frame_q;
  logic started_q;

  // First frame after enable stays on group 0
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      frame_q <= 9'h000;
      started_q <= 1'b0;
    end else if (!ENABLE_I) begin
      frame_q <= 9'h000;
      started_q <= 1'b0;
    end else if (FRAME_START_I) begin
      started_q <= 1'b1;
      if (started_q) begin
        frame_q <= (frame_q == `LPD_FRAME_MOD - 9'h001) ? 9'h000 : frame_q + 9'h001;
      end
    end
  end

  // ----------------------------------------------------------------
  // Serializer
  // ----------------------------------------------------------------
  logic [31:0] word_q;
  logic word_v_q;
  logic [4:0] idx_q;
  logic p_v_q;
  logic [23:0] p_pix_q;
  logic [1:0] p_x_q;
  logic [1:0] x_q;
  logic out_v_q;
  logic [23:0] out_data_q;
  logic out_adv;
  logic p_adv;
  logic ser_take;
  logic word_done;

  assign out_adv = !out_v_q || OUT_READY_I;
  assign p_adv = p_v_q && out_adv;
  assign ser_take = word_v_q && (!p_v_q || p_adv);
  assign word_done = ser_take && (idx_q == last_idx(BITS_PER_PIXEL_SEL_I));
  assign f_ready = !word_v_q || word_done;

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      word_q <= 32'h0000_0000;
      word_v_q <= 1'b0;
      idx_q <= 5'h00;
    end else if (f_ready) begin
      word_v_q <= f_valid;
      idx_q <= 5'h00;
      if (f_valid) begin
        word_q <= f_data;
      end
    end else if (ser_take) begin
      idx_q <= idx_q + 5'h01;
    end
  end

  // Colour spends three sub-pixel positions per pixel
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      x_q <= 2'h0;
    end else if (LINE_START_I) begin
      x_q <= 2'h0;
    end else if (ser_take) begin
      x_q <= x_q + ((DISPLAY_KIND_I == lpd_pkg::LPD_COLOR) ? 2'h3 : 2'h1);
    end
  end

  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      p_v_q <= 1'b0;
      p_pix_q <= 24'h000000;
      p_x_q <= 2'h0;
    end else if (!p_v_q || p_adv) begin
      p_v_q <= ser_take;
      if (ser_take) begin
        p_pix_q <= pick_pixel(word_q, BITS_PER_PIXEL_SEL_I, idx_q, MEMORY_ORDER_SEL_I);
        p_x_q <= x_q;
      end
    end
  end

  // ----------------------------------------------------------------
  // Palette lookup and dither
  // ----------------------------------------------------------------
  logic pal_on;
  logic [15:0] src16;
  logic [3:0] shade_r;
  logic [3:0] shade_g;
  logic [3:0] shade_b;
  logic on_r;
  logic on_g;
  logic on_b;
  logic [23:0] out_d;

  assign pal_on = is_pal(DISPLAY_KIND_I, BITS_PER_PIXEL_SEL_I);
  assign src16 = pal_on ? pal_mem[p_pix_q[7:0]] : p_pix_q[15:0];
  assign shade_r = (DISPLAY_KIND_I == lpd_pkg::LPD_MONO && !pal_on) ? p_pix_q[3:0]
                   : src16[`LPD_RED_MSB -: 4];
  assign shade_g = src16[`LPD_GRN_MSB -: 4];
  assign shade_b = src16[`LPD_BLU_MSB -: 4];

  lpd_dither u_dith_r (
    .shade_i(shade_r),
    .x_i(p_x_q),
    .frame_i(frame_q),
    .pat_six_sevenths_i(PATTERN_SIX_SEVENTHS_I),
    .pat_four_fifths_i(PATTERN_FOUR_FIFTHS_I),
    .pat_three_quarters_i(PATTERN_THREE_QUARTERS_I),
    .pat_five_sevenths_i(PATTERN_FIVE_SEVENTHS_I),
    .pat_two_thirds_i(PATTERN_TWO_THIRDS_I),
    .pat_three_fifths_i(PATTERN_THREE_FIFTHS_I),
    .pat_four_sevenths_i(PATTERN_FOUR_SEVENTHS_I),
    .pat_one_half_i(PATTERN_ONE_HALF_I),
    .on_o(on_r)
  );

  lpd_dither u_dith_g (
    .shade_i(shade_g),
    .x_i(p_x_q + 2'h1),
    .frame_i(frame_q),
    .pat_six_sevenths_i(PATTERN_SIX_SEVENTHS_I),
    .pat_four_fifths_i(PATTERN_FOUR_FIFTHS_I),
    .pat_three_quarters_i(PATTERN_THREE_QUARTERS_I),
    .pat_five_sevenths_i(PATTERN_FIVE_SEVENTHS_I),
    .pat_two_thirds_i(PATTERN_TWO_THIRDS_I),
    .pat_three_fifths_i(PATTERN_THREE_FIFTHS_I),
    .pat_four_sevenths_i(PATTERN_FOUR_SEVENTHS_I),
    .pat_one_half_i(PATTERN_ONE_HALF_I),
    .on_o(on_g)
  );

  lpd_dither u_dith_b (
    .shade_i(shade_b),
    .x_i(p_x_q + 2'h2),
    .frame_i(frame_q),
    .pat_six_sevenths_i(PATTERN_SIX_SEVENTHS_I),
    .pat_four_fifths_i(PATTERN_FOUR_FIFTHS_I),
    .pat_three_quarters_i(PATTERN_THREE_QUARTERS_I),
    .pat_five_sevenths_i(PATTERN_FIVE_SEVENTHS_I),
    .pat_two_thirds_i(PATTERN_TWO_THIRDS_I),
    .pat_three_fifths_i(PATTERN_THREE_FIFTHS_I),
    .pat_four_sevenths_i(PATTERN_FOUR_SEVENTHS_I),
    .pat_one_half_i(PATTERN_ONE_HALF_I),
    .on_o(on_b)
  );

  always_comb begin
    case (DISPLAY_KIND_I)
      lpd_pkg::LPD_TFT: begin
        if (!pal_on && BITS_PER_PIXEL_SEL_I == lpd_pkg::LPD_B24) begin
          out_d = p_pix_q;
        end else begin
          out_d = {src16[`LPD_RED_MSB:`LPD_RED_LSB], 3'h0, src16[`LPD_GRN_MSB:`LPD_GRN_LSB],
                   2'h0, src16[`LPD_BLU_MSB:0], 3'h0};
        end
      end
      lpd_pkg::LPD_MONO: out_d = {23'h0, on_r};
      lpd_pkg::LPD_COLOR: out_d = {21'h0, on_r, on_g, on_b};
      default: out_d = 24'h000000;
    endcase
  end

  // ----------------------------------------------------------------
  // Output stage
  // ----------------------------------------------------------------
  always_ff @(posedge CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      out_v_q <= 1'b0;
      out_data_q <= 24'h000000;
    end else if (out_adv) begin
      out_v_q <= p_v_q;
      if (p_v_q) begin
        out_data_q <= out_d;
      end
    end
  end

  assign OUT_VALID_O = out_v_q;
  assign OUT_DATA_O = out_data_q;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge CLK_I); endclocking
  default disable iff (!NRST_I);

  sequence s_wr_then_rd;
    PAL_SEL_I && PAL_WE_I ##1 PAL_SEL_I && !PAL_WE_I && PAL_ADDR_I == $past(PAL_ADDR_I);
  endsequence
  sequence s_frame_adv;
    ENABLE_I && FRAME_START_I && started_q && frame_q != `LPD_FRAME_MOD - 9'h001;
  endsequence

  property p_pal_rw;
    s_wr_then_rd |=> PAL_RDATA_O == {16'h0000, $past(wdata_lo, 2)};
  endproperty
  a_pal_rw: assert property (p_pal_rw) else $error("palette readback mismatch");
  property p_frame_adv;
    s_frame_adv |=> frame_q == $past(frame_q) + 9'h001;
  endproperty
  a_frame_adv: assert property (p_frame_adv) else $error("frame index not advanced");
  property p_frame_rst;
    !ENABLE_I |=> frame_q == 9'h000 && !started_q;
  endproperty
  a_frame_rst: assert property (p_frame_rst) else $error("frame index not restarted");
  property p_big1;
    ser_take && MEMORY_ORDER_SEL_I && BITS_PER_PIXEL_SEL_I == lpd_pkg::LPD_B8 && idx_q == 5'h00
    |=> p_pix_q[7:0] == $past(word_q[31:24]);
  endproperty
  a_big1: assert property (p_big1) else $error("big-endian pixel 0 wrong");
  property p_little1;
    ser_take && !MEMORY_ORDER_SEL_I && BITS_PER_PIXEL_SEL_I == lpd_pkg::LPD_B8 && idx_q == 5'h00
    |=> p_pix_q[7:0] == $past(word_q[7:0]);
  endproperty
  a_little1: assert property (p_little1) else $error("little-endian pixel 0 wrong");
  property p_tft_zero;
    p_adv && DISPLAY_KIND_I == lpd_pkg::LPD_TFT && pal_on
    |=> OUT_DATA_O[18:16] == 3'h0 && OUT_DATA_O[9:8] == 2'h0 && OUT_DATA_O[2:0] == 3'h0;
  endproperty
  a_tft_zero: assert property (p_tft_zero) else $error("unused TFT lines not zero");
  property p_tft24;
    p_adv && DISPLAY_KIND_I == lpd_pkg::LPD_TFT && BITS_PER_PIXEL_SEL_I == lpd_pkg::LPD_B24
    |=> OUT_DATA_O == $past(p_pix_q);
  endproperty
  a_tft24: assert property (p_tft24) else $error("24 bpp not passed through");
  property p_full_on;
    p_v_q && shade_r == `LPD_SHADE_FULL |-> on_r;
  endproperty
  a_full_on: assert property (p_full_on) else $error("shade 15 not on");
  property p_none_off;
    p_v_q && shade_g == `LPD_SHADE_NONE |-> !on_g;
  endproperty
  a_none_off: assert property (p_none_off) else $error("shade 0 not off");
endmodule // lpd_datapath

//--- sim/lpd_panel_sink.sv
// Panel-side sink for the datapath pixel stream.
// Assumes one clock; reports each taken pixel one edge later.
`timescale 1ns/1ns
module lpd_panel_sink (
  input wire logic clk_i,
  input wire logic nrst_i,
  input wire logic stall_i,
  input wire logic slow_i,
  input wire logic valid_i,
  input wire logic [23:0] data_i,
  output logic ready_o,
  output logic got_o,
  output logic [23:0] px_o
);
  logic ph_q;
  // Registered ready: a stall lands one edge late, as a real panel would
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_q <= 1'b0;
      ready_o <= 1'b0;
      got_o <= 1'b0;
      px_o <= 24'h000000;
    end else begin
      ph_q <= ~ph_q;
      ready_o <= !stall_i && (!slow_i || ph_q);
      got_o <= valid_i && ready_o;
      px_o <= data_i;
    end
  end
endmodule // lpd_panel_sink

//--- sim/testbench.sv
// Self-checking bench for the palette, dither and FIFO datapath.
// Assumes the design files and the panel sink are compiled first.
`timescale 1ns/1ns
module testbench;
  logic clk = 1'b0, nrst = 1'b0, en = 1'b0, fst = 1'b0, big = 1'b1, wv = 1'b0;
  logic psel = 1'b0, pwe = 1'b0, stall = 1'b0, slow = 1'b0, full = 1'b0;
  logic wr, ov, ordy, got;
  logic [31:0] wd = 32'h0, pwd = 32'h0, prd, ex;
  logic [7:0] pa = 8'h00;
  logic [23:0] od, px;
  lpd_pkg::lpd_kind_e kind = lpd_pkg::LPD_TFT;
  lpd_pkg::lpd_bpp_e bpp = lpd_pkg::LPD_B8;
  logic [27:0] pat [8] = '{28'h7EDBF7D, 28'hEB7DE, 28'hE7BD, 28'h6DB5EDA, 28'hDB6,
    28'hA5A5F, 28'h5A96A5C, 28'h5A};
  int ng [8] = '{7, 5, 4, 7, 3, 5, 7, 2};
  logic [7:0] da [9] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h10, 8'h11, 8'h12, 8'hFE, 8'hFF};
  logic [15:0] dv [9] = '{16'hF7FF, 16'h0FFF, 16'h9ABC, 16'h6123, 16'hEEF9, 16'hBD71,
    16'h7AE9, 16'h0000, 16'hFFFF};
  logic [7:0] ra [5] = '{8'hFF, 8'h00, 8'h03, 8'h7F, 8'hFE};
  logic [15:0] pal [256];
  logic [23:0] eq [$];
  int err_total = 0, checks = 0, fs = 0, x = 0, cyc = 0, n = 0;

  initial forever #50 clk = ~clk;

  lpd_datapath DUT (
    .CLK_I(clk),
    .NRST_I(nrst),
    .ENABLE_I(en),
    .FRAME_START_I(fst),
    .LINE_START_I(fst),
    .DISPLAY_KIND_I(kind),
    .BITS_PER_PIXEL_SEL_I(bpp),
    .MEMORY_ORDER_SEL_I(big),
    .PATTERN_SIX_SEVENTHS_I(pat[0]),
    .PATTERN_FOUR_FIFTHS_I(pat[1]),
    .PATTERN_THREE_QUARTERS_I(pat[2]),
    .PATTERN_FIVE_SEVENTHS_I(pat[3]),
    .PATTERN_TWO_THIRDS_I(pat[4]),
    .PATTERN_THREE_FIFTHS_I(pat[5]),
    .PATTERN_FOUR_SEVENTHS_I(pat[6]),
    .PATTERN_ONE_HALF_I(pat[7]),
    .WORD_VALID_I(wv),
    .WORD_DATA_I(wd),
    .WORD_READY_O(wr),
    .PAL_SEL_I(psel),
    .PAL_WE_I(pwe),
    .PAL_ADDR_I(pa),
    .PAL_WDATA_I(pwd),
    .PAL_RDATA_O(prd),
    .OUT_VALID_O(ov),
    .OUT_DATA_O(od),
    .OUT_READY_I(ordy)
  );

  lpd_panel_sink panel (.clk_i(clk), .nrst_i(nrst), .stall_i(stall), .slow_i(slow),
    .valid_i(ov), .data_i(od), .ready_o(ordy), .got_o(got), .px_o(px));

  task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic conclude;
    $display("checks %0d errors %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  function automatic logic on_bit(int l, int xp, int f);
    int k;
    logic [27:0] g;
    if (l == 15) return 1'b1;
    if (l == 0) return 1'b0;
    k = l >= 8 ? 14 - l : (l >= 4 ? l : l - 1);
    g = pat[k] >> (4 * (ng[k] - 1 - f % ng[k]));
    return g[3 - xp % 4] ^ (l < 8);
  endfunction

  // Upper half carries junk: the entry must ignore it
  task automatic pal_wr(logic [7:0] a, logic [15:0] d);
    psel <= 1'b1;
    pwe <= 1'b1;
    pa <= a;
    pwd <= {~d, d};
    pal[a] = d;
    @(posedge clk);
  endtask

  task automatic pal_rd(logic [7:0] a);
    psel <= 1'b1;
    pwe <= 1'b0;
    pa <= a;
    @(posedge clk);
    @(negedge clk);
    chk("palette", {16'h0000, pal[a]}, prd);
    @(posedge clk);
  endtask

  task automatic cfg(lpd_pkg::lpd_kind_e k, lpd_pkg::lpd_bpp_e b, logic o);
    kind <= k;
    bpp <= b;
    big <= o;
    @(posedge clk);
  endtask

  task automatic send(logic [31:0] w);
    int b, f;
    logic [7:0] p;
    logic [15:0] e;
    b = (bpp == lpd_pkg::LPD_B24) ? 32 : (1 << bpp);
    f = fs > 0 ? fs - 1 : 0;
    for (int i = 0; i < 32 / b; i++) begin
      p = 8'((big ? w >> (32 - b * (i + 1)) : w >> (b * i)) & ((1 << b) - 1));
      e = pal[p];
      if (b == 32) eq.push_back(w[23:0]);
      else if (kind == lpd_pkg::LPD_TFT)
        eq.push_back({e[15:11], 3'h0, e[10:5], 2'h0, e[4:0], 3'h0});
      else if (kind == lpd_pkg::LPD_MONO)
        eq.push_back({23'h0, on_bit(b == 4 ? p[3:0] : e[15:12], x, f)});
      else eq.push_back({21'h0, on_bit(e[15:12], x, f), on_bit(e[10:7], x + 1, f),
        on_bit(e[4:1], x + 2, f)});
      x += (kind == lpd_pkg::LPD_COLOR) ? 3 : 1;
    end
    wd <= w;
    wv <= 1'b1;
    do @(negedge clk); while (wr !== 1'b1);
    @(posedge clk);
  endtask

  task automatic drain;
    wv <= 1'b0;
    while (eq.size() != 0) @(posedge clk);
    repeat (2) @(posedge clk);
  endtask

  task automatic frame;
    fst <= 1'b1;
    fs++;
    x = 0;
    @(posedge clk);
    fst <= 1'b0;
    @(posedge clk);
  endtask

  always @(negedge clk) begin
    if (got === 1'b1) begin
      ex = eq.size() ? {8'h00, eq.pop_front()} : 32'hFFFFFFFF;
      chk("pixel", ex, {8'h00, px});
    end
  end

  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      err_total++;
      conclude();
    end
  end

  // ------------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk);
    nrst <= 1'b1;
    @(posedge clk);
    en <= 1'b1;
    for (int i = 0; i < 256; i++) pal_wr(8'(i), 16'(i * 40503));
    for (int i = 0; i < 9; i++) pal_wr(da[i], dv[i]);
    for (int i = 0; i < 5; i++) pal_rd(ra[i]);
    psel <= 1'b0;
    for (int c = 0; c < 3; c++) begin
      cfg(lpd_pkg::LPD_TFT, c == 2 ? lpd_pkg::LPD_B24 : lpd_pkg::LPD_B8, c != 1);
      send(32'hFF00_7F80);
      send(32'h13FE_0112);
      drain();
    end
    // Sink stalled so the FIFO must refuse once it holds its depth
    stall <= 1'b1;
    @(posedge clk);
    wv <= 1'b1;
    while (!full && n < 40) begin
      wd <= {8'hC3, 24'(n * 66051)};
      @(negedge clk);
      if (wr === 1'b1) eq.push_back(wd[23:0]);
      if (wr === 1'b1) n++;
      else full = 1'b1;
      @(posedge clk);
    end
    chk("refused", 32'h1, {31'h0, full});
    chk("accepted", 32'h1, {31'h0, n >= 32});
    stall <= 1'b0;
    drain();
    chk("ready", 32'h1, {31'h0, wr});
    cfg(lpd_pkg::LPD_MONO, lpd_pkg::LPD_B2, 1'b1);
    slow <= 1'b1;
    repeat (9) begin
      frame();
      send(32'h1B4E_E41B);
      send(32'hC936_2D78);
      drain();
    end
    // Unpaletted mono: the pixel itself is the shade, all 16 levels
    cfg(lpd_pkg::LPD_MONO, lpd_pkg::LPD_B4, 1'b0);
    frame();
    send(32'hFEDC_BA98);
    send(32'h7654_3210);
    drain();
    en <= 1'b0;
    cfg(lpd_pkg::LPD_COLOR, lpd_pkg::LPD_B8, 1'b0);
    en <= 1'b1;
    fs = 0;
    repeat (8) begin
      frame();
      send(32'h1312_1110);
      send(32'h1011_1312);
      drain();
    end
    conclude();
  end
endmodule // testbench
